// *** logic/dual_wiper_pkg.sv ***
/*
 * Shared constants and types for the dual wiper serial command block:
 * opcodes, byte layouts, reset values and the write cycle timing.
 * Assumes a 250 MHz system clock; SCL phases must also span at least 10 clk_sys cycles.
 */
package dual_wiper_pkg;

  // geometry
  localparam int        POTS     = 2;
  localparam int        SETTINGS = 4;
  localparam int        WIDTH    = 8;
  localparam int        TAPS     = 256;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // instruction opcodes, upper nibble of the instruction byte
  localparam logic [3:0] OP_READ_WIPER       = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER      = 4'hA;
  localparam logic [3:0] OP_READ_SETTING     = 4'hB;
  localparam logic [3:0] OP_WRITE_SETTING    = 4'hC;
  localparam logic [3:0] OP_COPY_TO_WIPER    = 4'hD;
  localparam logic [3:0] OP_COPY_TO_SETTING  = 4'hE;
  localparam logic [3:0] OP_GCOPY_TO_WIPER   = 4'h1;
  localparam logic [3:0] OP_GCOPY_TO_SETTING = 4'h8;
  localparam logic [3:0] OP_STEP             = 4'h2;

  // values after reset
  localparam logic [7:0] STORED_RESET = 8'h80;
  localparam logic [6:0] SYNC_RESET   = 7'h07;

  // synchroniser lanes
  localparam int SYN_SCL   = 0;
  localparam int SYN_SDA   = 1;
  localparam int SYN_GUARD = 2;
  localparam int SYN_STRAP = 3;
  localparam int SYN_W     = 7;

  // nonvolatile write cycle
  localparam int CLK_MHZ          = 250;
  localparam int NV_WRITE_TYP_MS  = 5;
  localparam int NV_WRITE_MAX_MS  = 10;
  localparam int CYCLES_PER_MS    = CLK_MHZ * 1000;
  localparam int NV_WRITE_TYP_CYC = NV_WRITE_TYP_MS * CYCLES_PER_MS;
  localparam int NV_WRITE_MAX_CYC = NV_WRITE_MAX_MS * CYCLES_PER_MS;

  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] setting;
    logic       zero;
    logic       pot;
  } instr_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ID    = 3'h1,
    ST_INSTR = 3'h2,
    ST_DATA  = 3'h3,
    ST_READ  = 3'h4,
    ST_STEP  = 3'h5,
    ST_SKIP  = 3'h6
  } link_state_e;

endpackage : dual_wiper_pkg

// *** logic/dual_wiper_serial_command.sv ***
/*
 * Two-wire slave and instruction interpreter for two 256-tap wipers,
 * each with four stored settings and a one-hot tap select output.
 * Assumes an external master drives SCL; SCL high and low phases each
 * last at least 10 clk_sys cycles so the sampled lines keep up.
 */
`timescale 1ns/1ps

// Overview of operation
// - each pot's 8-bit wiper decodes to exactly one of 256 taps.
// - wiper 00 selects the low terminal tap, FF the high terminal tap.
// - write guard low blocks every stored-setting write, copies included.
// - data changes only while clock low; high-phase changes are start/stop.
// - commands begin with start; all traffic ignored until a start.
// - every transfer ends with a stop condition.
// - transmitter releases data after eight bits; receiver pulls low on ninth.
// - acknowledge matching id byte, good instruction byte, and data byte.
// - stop ending a stored write starts the write cycle, inputs disabled.
// - polling id during the write cycle gets no acknowledge until done.
// - id byte: upper nibble device type, lower nibble slave address.
// - slave address must match all four strap inputs to continue.
// - instruction: opcode 7:4, setting 3:2, bit 1 zero, pot bit 0.
// - setting bits 00..11 choose stored setting 0..3 of that pot.
// - 1001 reads wiper, 1011 reads selected stored setting.
// - 1010 loads data into wiper, 1100 writes data to stored setting.
// - 1101 copies setting to wiper, 1110 copies wiper to setting.
// - global 0001 and 1000 copy settings and wipers for every pot.
// - 0010 enables stepping of the selected pot's wiper.
// - each clock pulse steps up with data high, down with data low.
// - any stored-setting write completes within 10 ms.
// - after power-up each wiper is loaded from its stored setting 0.
module dual_wiper_serial_command #(
  parameter int         NV_WRITE_CYCLES = dual_wiper_pkg::NV_WRITE_TYP_CYC,
  // arbitrary device type code, not tied to any real part
  parameter logic [3:0] DEVICE_TYPE     = 4'hA
) (
  // clocks and reset
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  input  wire logic                          scl_clk,
  // two-wire data pin
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe_n,
  // straps and write guard
  input  wire logic [3:0]                    strap_address_inputs,
  input  wire logic                          write_guard_n,
  // potentiometer side
  output logic [dual_wiper_pkg::POTS-1:0][7:0]   wiper_position,
  output logic [dual_wiper_pkg::POTS-1:0][255:0] tap_select,
  output logic                               nv_busy
);

  localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);

  if (NV_WRITE_CYCLES < 1 ||
      NV_WRITE_CYCLES > dual_wiper_pkg::NV_WRITE_MAX_CYC) begin : g_chk
    $error("NV_WRITE_CYCLES out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  // link domain: capture each data bit on the rising clock edge
  // the device only listens to scl, it never drives it
  logic link_bit_reg;
  logic link_tgl_reg;

  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_bit_reg <= 1'b1;
      link_tgl_reg <= 1'b0;
    end else begin
      link_bit_reg <= sda_in;
      link_tgl_reg <= ~link_tgl_reg;
    end
  end

  // toggle crossing; the bit is stable until the next scl rise
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= link_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  logic rise_ev;
  logic rx_bit;
  assign rise_ev = tgl_s2_reg ^ tgl_s3_reg;
  assign rx_bit  = link_bit_reg;

  //////////////////////////////////////////////////////////////////////////
  // pin sampling: three flops, a change counts once stages 2 and 3 agree
  logic [dual_wiper_pkg::SYN_W-1:0] pin_raw;
  logic [dual_wiper_pkg::SYN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;

  assign pin_raw = {strap_address_inputs, write_guard_n, sda_in, scl_clk};

  for (genvar g = 0; g < dual_wiper_pkg::SYN_W; g++) begin : g_sync
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        s1_reg[g]   <= dual_wiper_pkg::SYNC_RESET[g];
        s2_reg[g]   <= dual_wiper_pkg::SYNC_RESET[g];
        s3_reg[g]   <= dual_wiper_pkg::SYNC_RESET[g];
        filt_reg[g] <= dual_wiper_pkg::SYNC_RESET[g];
      end else begin
        s1_reg[g] <= pin_raw[g];
        s2_reg[g] <= s1_reg[g];
        s3_reg[g] <= s2_reg[g];
        if (s2_reg[g] == s3_reg[g]) begin
          filt_reg[g] <= s3_reg[g];
        end
      end
    end
  end

  logic       scl_f, sda_f, guard_f;
  logic [3:0] strap_f;
  logic       scl_prev_reg, sda_prev_reg;
  logic       start_ev, stop_ev, fall_ev;

  assign scl_f   = filt_reg[dual_wiper_pkg::SYN_SCL];
  assign sda_f   = filt_reg[dual_wiper_pkg::SYN_SDA];
  assign guard_f = filt_reg[dual_wiper_pkg::SYN_GUARD];
  assign strap_f = filt_reg[dual_wiper_pkg::SYN_STRAP +: 4];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
    end
  end

  // data edges while the clock stays high are framing only
  assign start_ev = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
  assign stop_ev  = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;
  assign fall_ev  = scl_prev_reg && !scl_f;

  //////////////////////////////////////////////////////////////////////////
  // command decode
  function automatic logic instr_legal(input dual_wiper_pkg::instr_s i);
    logic ok;
    ok = 1'b0;
    case (i.opcode)
      dual_wiper_pkg::OP_READ_WIPER,
      dual_wiper_pkg::OP_WRITE_WIPER,
      dual_wiper_pkg::OP_STEP:           ok = (i.setting == 2'h0);
      dual_wiper_pkg::OP_READ_SETTING,
      dual_wiper_pkg::OP_WRITE_SETTING,
      dual_wiper_pkg::OP_COPY_TO_WIPER,
      dual_wiper_pkg::OP_COPY_TO_SETTING: ok = 1'b1;
      dual_wiper_pkg::OP_GCOPY_TO_WIPER,
      dual_wiper_pkg::OP_GCOPY_TO_SETTING: ok = !i.pot;
      default:                           ok = 1'b0;
    endcase
    return ok && !i.zero;
  endfunction : instr_legal

  dual_wiper_pkg::link_state_e state_reg, after_reg, after_next;
  logic [3:0]                  bit_cnt_reg;
  logic [6:0]                  shift_reg;
  logic [7:0]                  byte_full, tx_reg;
  logic                        ack_go_reg, accept, busy_reg;
  logic                        nv_pend_reg, step_arm_reg, step_up_reg;
  logic [7:0]                  nv_data_reg;
  dual_wiper_pkg::instr_s      instr_reg, instr_in;
  logic [7:0]                  wiper_reg  [dual_wiper_pkg::POTS];
  logic [7:0]                  stored_reg [dual_wiper_pkg::POTS]
                                          [dual_wiper_pkg::SETTINGS];

  assign byte_full = {shift_reg, rx_bit};
  assign instr_in  = dual_wiper_pkg::instr_s'(byte_full);

  logic byte_end, exec_instr, exec_data;
  assign byte_end   = rise_ev && !start_ev && !stop_ev &&
                      bit_cnt_reg == 4'h7;
  assign exec_instr = byte_end && state_reg == dual_wiper_pkg::ST_INSTR &&
                      accept;
  assign exec_data  = byte_end && state_reg == dual_wiper_pkg::ST_DATA;

  always_comb begin
    accept     = 1'b0;
    after_next = dual_wiper_pkg::ST_SKIP;
    unique case (state_reg)
      dual_wiper_pkg::ST_ID: begin
        // polling while the write cycle runs sees no acknowledge
        accept = byte_full[7:4] == DEVICE_TYPE &&
                 byte_full[3:0] == strap_f && !busy_reg;
        after_next = dual_wiper_pkg::ST_INSTR;
      end
      dual_wiper_pkg::ST_INSTR: begin
        accept = instr_legal(instr_in);
        unique case (instr_in.opcode)
          dual_wiper_pkg::OP_READ_WIPER,
          dual_wiper_pkg::OP_READ_SETTING:
            after_next = dual_wiper_pkg::ST_READ;
          dual_wiper_pkg::OP_WRITE_WIPER,
          dual_wiper_pkg::OP_WRITE_SETTING:
            after_next = dual_wiper_pkg::ST_DATA;
          dual_wiper_pkg::OP_STEP:
            after_next = dual_wiper_pkg::ST_STEP;
          default:
            after_next = dual_wiper_pkg::ST_SKIP;
        endcase
      end
      dual_wiper_pkg::ST_DATA:  accept = 1'b1;
      dual_wiper_pkg::ST_IDLE,
      dual_wiper_pkg::ST_READ,
      dual_wiper_pkg::ST_STEP,
      dual_wiper_pkg::ST_SKIP:  accept = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // byte sequencer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= dual_wiper_pkg::ST_IDLE;
      after_reg   <= dual_wiper_pkg::ST_SKIP;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 7'h00;
      ack_go_reg  <= 1'b0;
      instr_reg   <= dual_wiper_pkg::instr_s'(8'h00);
      tx_reg      <= 8'h00;
    end else if (start_ev) begin
      state_reg   <= dual_wiper_pkg::ST_ID;
      bit_cnt_reg <= 4'h0;
      ack_go_reg  <= 1'b0;
    end else if (stop_ev) begin
      state_reg  <= dual_wiper_pkg::ST_IDLE;
      ack_go_reg <= 1'b0;
    end else if (rise_ev && state_reg != dual_wiper_pkg::ST_IDLE &&
                 state_reg != dual_wiper_pkg::ST_STEP &&
                 state_reg != dual_wiper_pkg::ST_SKIP) begin
      if (bit_cnt_reg == dual_wiper_pkg::BYTE_BITS) begin
        // ninth clock: the acknowledge bit itself
        bit_cnt_reg <= 4'h0;
        ack_go_reg  <= 1'b0;
        state_reg   <= ack_go_reg ? after_reg : dual_wiper_pkg::ST_SKIP;
      end else begin
        shift_reg   <= byte_full[6:0];
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (byte_end) begin
          ack_go_reg <= accept;
          after_reg  <= after_next;
          if (state_reg == dual_wiper_pkg::ST_INSTR) begin
            instr_reg <= instr_in;
            tx_reg    <= instr_in.opcode == dual_wiper_pkg::OP_READ_WIPER ?
                         wiper_reg[instr_in.pot] :
                         stored_reg[instr_in.pot][instr_in.setting];
          end
        end
      end
    end
  end

  // stored writes wait for the stop; a new start abandons them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      nv_pend_reg <= 1'b0;
      nv_data_reg <= 8'h00;
    end else if (start_ev || stop_ev) begin
      nv_pend_reg <= 1'b0;
    end else if (exec_instr &&
                 (instr_in.opcode == dual_wiper_pkg::OP_COPY_TO_SETTING ||
                  instr_in.opcode == dual_wiper_pkg::OP_GCOPY_TO_SETTING)) begin
      nv_pend_reg <= 1'b1;
    end else if (exec_data &&
                 instr_reg.opcode == dual_wiper_pkg::OP_WRITE_SETTING) begin
      nv_pend_reg <= 1'b1;
      nv_data_reg <= byte_full;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // step mode: the move happens at the end of the pulse, so the pulse
  // that carries a stop never moves the wiper
  logic step_go;
  assign step_go = fall_ev && step_arm_reg &&
                   state_reg == dual_wiper_pkg::ST_STEP;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      step_arm_reg <= 1'b0;
      step_up_reg  <= 1'b0;
    end else if (start_ev || stop_ev || step_go) begin
      step_arm_reg <= 1'b0;
    end else if (rise_ev && state_reg == dual_wiper_pkg::ST_STEP) begin
      step_arm_reg <= 1'b1;
      step_up_reg  <= rx_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wipers, stored settings and tap decode
  logic recall_reg;
  logic commit;
  assign commit = stop_ev && nv_pend_reg && guard_f;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      recall_reg <= 1'b1;
    end else begin
      recall_reg <= 1'b0;
    end
  end

  for (genvar p = 0; p < dual_wiper_pkg::POTS; p++) begin : g_pot
    logic sel_pot;
    assign sel_pot = instr_reg.pot == 1'(p);

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        wiper_reg[p] <= dual_wiper_pkg::STORED_RESET;
      end else if (recall_reg) begin
        wiper_reg[p] <= stored_reg[p][0];
      end else if (exec_instr &&
                   ((instr_in.opcode == dual_wiper_pkg::OP_COPY_TO_WIPER &&
                     instr_in.pot == 1'(p)) ||
                    instr_in.opcode == dual_wiper_pkg::OP_GCOPY_TO_WIPER)) begin
        wiper_reg[p] <= stored_reg[p][instr_in.setting];
      end else if (exec_data && sel_pot &&
                   instr_reg.opcode == dual_wiper_pkg::OP_WRITE_WIPER) begin
        wiper_reg[p] <= byte_full;
      end else if (step_go && sel_pot) begin
        if (step_up_reg && wiper_reg[p] != 8'hFF) begin
          wiper_reg[p] <= wiper_reg[p] + 8'h01;
        end else if (!step_up_reg && wiper_reg[p] != 8'h00) begin
          wiper_reg[p] <= wiper_reg[p] - 8'h01;
        end
      end
    end

    for (genvar s = 0; s < dual_wiper_pkg::SETTINGS; s++) begin : g_set
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          stored_reg[p][s] <= dual_wiper_pkg::STORED_RESET;
        end else if (commit && instr_reg.setting == 2'(s) &&
                     (sel_pot || instr_reg.opcode ==
                      dual_wiper_pkg::OP_GCOPY_TO_SETTING)) begin
          stored_reg[p][s] <=
            instr_reg.opcode == dual_wiper_pkg::OP_WRITE_SETTING ?
            nv_data_reg : wiper_reg[p];
        end
      end
    end

    // tap 0 is the low terminal, tap 255 the high terminal
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        tap_select[p] <= 256'h1 << dual_wiper_pkg::STORED_RESET;
      end else begin
        tap_select[p] <= 256'h1 << wiper_reg[p];
      end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        wiper_position[p] <= dual_wiper_pkg::STORED_RESET;
      end else begin
        wiper_position[p] <= wiper_reg[p];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write cycle timer; the id byte is refused while it runs
  logic [BUSY_W-1:0] busy_cnt_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (commit) begin
      busy_reg     <= 1'b1;
      busy_cnt_reg <= BUSY_W'(NV_WRITE_CYCLES - 1);
    end else if (busy_reg) begin
      if (busy_cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      nv_busy <= 1'b0;
    end else begin
      nv_busy <= busy_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data pin: driven only after the clock has fallen; start and stop release it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_n <= 1'b1;
    end else if (start_ev || stop_ev) begin
      sda_oe_n <= 1'b1;
    end else if (fall_ev) begin
      sda_oe_n <= !((bit_cnt_reg == dual_wiper_pkg::BYTE_BITS &&
                     ack_go_reg) ||
                    (state_reg == dual_wiper_pkg::ST_READ &&
                     bit_cnt_reg < dual_wiper_pkg::BYTE_BITS &&
                     !tx_reg[3'(4'h7 - bit_cnt_reg)]));
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence id_end_s;
    byte_end && state_reg == dual_wiper_pkg::ST_ID;
  endsequence

  sequence ack_slot_s;
    fall_ev && !start_ev && !stop_ev &&
    bit_cnt_reg == dual_wiper_pkg::BYTE_BITS && ack_go_reg;
  endsequence

  tap_onehot_a: assert property (
    $onehot(tap_select[0]) && $onehot(tap_select[1]))
    else $error("tap select not one-hot");

  tap_low_end_a: assert property (
    wiper_reg[0] == 8'h00 |=> tap_select[0][0])
    else $error("wiper zero does not select low tap");

  guard_block_a: assert property (
    stop_ev && !guard_f |=> $stable(stored_reg[0][0]) &&
                            $stable(stored_reg[1][3]) && !$rose(busy_reg))
    else $error("stored write while guarded");

  start_entry_a: assert property (
    start_ev |=> state_reg == dual_wiper_pkg::ST_ID && bit_cnt_reg == 4'h0)
    else $error("start not taken");

  ack_drive_a: assert property (
    ack_slot_s |=> !sda_oe_n)
    else $error("acknowledge not driven");

  busy_nack_a: assert property (
    id_end_s ##0 busy_reg |=> !ack_go_reg)
    else $error("acknowledge given while busy");

  strap_match_a: assert property (
    id_end_s ##0 (byte_full[3:0] != strap_f) |=> !ack_go_reg)
    else $error("address mismatch acknowledged");

  write_start_a: assert property (
    commit |=> busy_reg ##1 busy_reg)
    else $error("write cycle not started");

  step_sat_a: assert property (
    step_go && step_up_reg && wiper_reg[instr_reg.pot] == 8'hFF
    |=> wiper_reg[instr_reg.pot] == 8'hFF)
    else $error("step passed top tap");

  bad_instr_a: assert property (
    byte_end && state_reg == dual_wiper_pkg::ST_INSTR && instr_in.zero
    |=> !ack_go_reg ##1 $stable(wiper_reg[0]))
    else $error("bad instruction acknowledged");

  recall_a: assert property (
    recall_reg |=> wiper_reg[1] == $past(stored_reg[1][0]))
    else $error("power-up recall missing");

endmodule : dual_wiper_serial_command

// *** verif/tb_top.sv ***
/* Self-checking bench: hand-written scenarios through the master model.
   Assumes the package, the design and wire_master compile first. */
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0] DEV = 4'hA; // arbitrary type code
  localparam logic [7:0] ID  = {DEV, 4'h6};
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic              write_guard_n = 1'b1;
  logic [3:0]        strap_address_inputs = 4'h6;
  logic              scl_clk, sda_drv, sda_out, sda_oe_n, nv_busy;
  logic [1:0][7:0]   wiper_position;
  logic [1:0][255:0] tap_select;
  logic [7:0]        rx;
  logic [2:0]        ak;
  int                bad_count = 0;
  int                n_compared = 0;
  wire logic sda_in = sda_drv & (sda_oe_n | sda_out);
  always #2 clk_sys = ~clk_sys;
  dual_wiper_serial_command #(.NV_WRITE_CYCLES(400), .DEVICE_TYPE(DEV))
    u_dual_wiper_serial_command (.clk_sys, .arst_n, .scl_clk, .sda_in,
    .sda_out, .sda_oe_n, .strap_address_inputs, .write_guard_n,
    .wiper_position, .tap_select, .nv_busy);
  wire_master u_wire_master (.scl_clk, .sda_drv, .sda_line(sda_in));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [255:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic frame(input logic [7:0] id, ins, dat, input int n);
    logic [7:0] x;
    ak = 3'h0;
    @(negedge clk_sys);
    u_wire_master.start_c();
    u_wire_master.byte_x(id, x, ak[0]);
    if (n > 1) u_wire_master.byte_x(ins, x, ak[1]);
    if (n > 2) u_wire_master.byte_x(dat, rx, ak[2]);
    u_wire_master.stop_c();
  endtask : frame
  // id-only frames until the write cycle lets the id byte be acknowledged
  task automatic poll_done();
    ak = 3'h0;
    for (int i = 0; i < 20 && !ak[0]; i++) frame(ID, 8'h00, 8'h00, 1);
  endtask : poll_done
  ////////////////////////////////////////////////////////////
  task automatic t_write();
    frame(ID, 8'hA1, 8'hFF, 3);
    chk(ak, 3'h7);
    chk(tap_select[1], 256'h1 << 255);
    frame(ID, 8'h91, 8'hFF, 3);
    chk(rx, 8'hFF);
    frame(ID, 8'hA0, 8'h00, 3);
    chk(tap_select[0], 256'h1);
  endtask : t_write
  task automatic t_refuse();
    frame({DEV, 4'h7}, 8'hA0, 8'h11, 3);
    chk(ak, 3'h0);
    frame({4'h3, 4'h6}, 8'hA0, 8'h11, 3);
    chk(ak, 3'h0);
    frame(ID, 8'hA2, 8'h11, 3);
    chk(ak, 3'h1);
    frame(ID, 8'h30, 8'h11, 3);
    chk(ak, 3'h1);
    chk(wiper_position[0], 8'h00);
  endtask : t_refuse
  task automatic t_stored();
    frame(ID, 8'hC8, 8'h5A, 3);
    chk(ak, 3'h7);
    frame(ID, 8'h00, 8'h00, 1);
    chk({nv_busy, ak[0]}, 2'b10);
    for (int i = 0; i < 20 && !ak[0]; i++) frame(ID, 8'h00, 8'h00, 1);
    chk({nv_busy, ak[0]}, 2'b01);
    frame(ID, 8'hB8, 8'hFF, 3);
    chk(rx, 8'h5A);
    frame(ID, 8'hD8, 8'h00, 2);
    chk(wiper_position[0], 8'h5A);
    frame(ID, 8'hEC, 8'h00, 2);
    poll_done();
    frame(ID, 8'hBC, 8'hFF, 3);
    chk(rx, 8'h5A);
  endtask : t_stored
  task automatic t_guard();
    @(negedge clk_sys) write_guard_n = 1'b0;
    frame(ID, 8'hED, 8'h00, 2);
    chk(nv_busy, 1'b0);
    frame(ID, 8'hBD, 8'hFF, 3);
    chk(rx, 8'h80);
    @(negedge clk_sys) write_guard_n = 1'b1;
  endtask : t_guard
  task automatic t_step();
    logic [7:0] x;
    logic       a;
    @(negedge clk_sys);
    u_wire_master.start_c();
    u_wire_master.byte_x(ID, x, a);
    u_wire_master.byte_x(8'h21, x, a);
    chk(a, 1'b1);
    u_wire_master.bit_x(1'b1, a);
    u_wire_master.bit_x(1'b0, a);
    u_wire_master.bit_x(1'b0, a);
    u_wire_master.stop_c();
    chk(wiper_position[1], 8'hFD);
    frame(ID, 8'h84, 8'h00, 2);
    poll_done();
    chk({nv_busy, ak[0]}, 2'b01);
    frame(ID, 8'hB5, 8'hFF, 3);
    chk(rx, 8'hFD);
    frame(ID, 8'hB4, 8'hFF, 3);
    chk(rx, 8'h5A);
    frame(ID, 8'h10, 8'h00, 2);
    chk(wiper_position, 16'h8080);
  endtask : t_step
  initial begin
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(tap_select[0], 256'h1 << 128);
    t_write();
    t_refuse();
    t_stored();
    t_guard();
    t_step();
    end_sim();
  end
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
endmodule : tb_top

// *** verif/wire_master.sv ***
/* Two-wire bus master model: makes the clock, drives data open drain.
   Assumes the bench ANDs sda_drv with the device's pull-down. */
`timescale 1ns/1ps
module wire_master (
  // bus lines
  output logic      scl_clk,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // 48 ns phases, not 16: the device needs ten sampled cycles per phase
  localparam int HALF = 48;
  initial begin
    scl_clk = 1'b1;
    sda_drv = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic start_c();
    #3;
    sda_drv = 1'b0;
    #(HALF);
    scl_clk = 1'b0;
  endtask : start_c
  task automatic bit_x(input logic b, output logic r);
    #8;
    sda_drv = b;
    #(HALF - 8);
    scl_clk = 1'b1;
    #(HALF);
    r = sda_line;
    scl_clk = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(1'b1, a);
    ack = ~a;
  endtask : byte_x
  task automatic stop_c();
    #8;
    sda_drv = 1'b0;
    #(HALF - 8);
    scl_clk = 1'b1;
    #(HALF);
    sda_drv = 1'b1;
    #(HALF);
  endtask : stop_c
endmodule : wire_master
